/* File: common/ipc_pkg.sv */
package ipc_pkg;

  // Clock and reset timing.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RESET_MIN_CYC = 8;

  // Fetch addresses.
  localparam logic [31:0] RESET_PC  = 32'h0000_0000;
  localparam logic [31:0] INST_STEP = 32'h0000_0004;

  // External interrupt level codes.
  localparam logic [3:0] IRL_IDLE = 4'h0;
  localparam logic [3:0] IRL_NMI  = 4'hf;

  // Register numbers with a special role.
  localparam logic [4:0] REG_G0   = 5'h00;
  localparam logic [4:0] REG_LINK = 5'h0f;

  // Trap base word layout: base in bits 31:12, type in bits 11:4.
  localparam int unsigned TBA_LSB = 12;
  localparam logic [3:0]  TT_PAD  = 4'h0;

  // Prefetch buffer depth and internal op counts.
  localparam int unsigned PF_DEPTH  = 2;
  localparam logic [1:0]  IOP_NONE  = 2'h0;
  localparam logic [1:0]  IOP_ONE   = 2'h1;
  localparam logic [1:0]  IOP_TWO   = 2'h2;
  localparam logic [1:0]  IOP_THREE = 2'h3;

  typedef enum logic [3:0] {
    IPC_ALU, IPC_LD, IPC_LDD, IPC_ST, IPC_STD,
    IPC_ATOM, IPC_REGISTER_JUMP, IPC_TRAP_RETURN, IPC_CALL, IPC_BR
  } ipc_cls_e;

  typedef enum logic [1:0] {IPC_RUN, IPC_TRAP_GAP, IPC_HALT} ipc_state_e;

  // One pipeline slot: a fetched instruction or an inserted op.
  typedef struct packed {
    logic        vld;
    logic        internal_op_insert;
    ipc_cls_e    cls;
    logic [4:0]  rd;
    logic [4:0]  rs1;
    logic [4:0]  rs2;
    logic        annul;
    logic        taken;
    logic [31:0] target;
    logic [31:0] pc;
  } ipc_inst_s;

  // Internal ops inserted behind each instruction class.
  function automatic logic [1:0] ipc_iops(input ipc_cls_e c);
    case (c)
      IPC_LD, IPC_REGISTER_JUMP, IPC_TRAP_RETURN: ipc_iops = IOP_ONE;
      IPC_LDD, IPC_ST:            ipc_iops = IOP_TWO;
      IPC_STD, IPC_ATOM:          ipc_iops = IOP_THREE;
      default:                    ipc_iops = IOP_NONE;
    endcase
  endfunction

  // Data bus cycles that steal fetch slots.
  function automatic logic [1:0] ipc_dcyc(input ipc_cls_e c);
    ipc_dcyc = (c == IPC_REGISTER_JUMP || c == IPC_TRAP_RETURN) ? IOP_NONE : ipc_iops(c);
  endfunction

endpackage

/* File: hdl/ipc_irl_sync.sv */
module ipc_irl_sync import ipc_pkg::*; #(
  parameter int unsigned W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] level_i,
  output logic      [W-1:0] level_o
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Three flop stages; the level moves only after two equal samples.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      level_o <= '0;
    end else begin
      s1_reg <= level_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s2_reg;
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_irl_two_samples: assert property (
    level_o != $past(level_o) |-> $past(s2_reg) == $past(s3_reg))
    else $error("Level recognised without two equal samples.");

endmodule

/* File: hdl/ipc_prefetch_buf.sv */
module ipc_prefetch_buf import ipc_pkg::*; #(
  parameter int unsigned DEPTH = PF_DEPTH,
  localparam int unsigned CW   = $clog2(DEPTH + 1),
  localparam int unsigned PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          flush_i,
  input  wire logic          in_valid_i,
  output logic               in_ready_o,
  input  wire ipc_inst_s     in_data_i,
  output logic               out_valid_o,
  input  wire logic          out_ready_i,
  output ipc_inst_s          out_data_o,
  output logic [CW-1:0]      free_o
);

  ipc_inst_s     mem [DEPTH];
  logic [PW-1:0] wr_reg;
  logic [PW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    nxt = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // Handshakes and occupancy.
  assign in_ready_o  = cnt_reg != CW'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o  = mem[rd_reg];
  assign free_o      = CW'(DEPTH) - cnt_reg;
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointers; a flush drops every held instruction.
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= nxt(wr_reg);
      end
      if (pop) begin
        rd_reg <= nxt(rd_reg);
      end
      cnt_reg <= cnt_reg + CW'(push) - CW'(pop);
    end
  end

  // Storage needs no reset; occupancy guards every read.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

endmodule

/* File: hdl/ipc_core.sv */
module ipc_core import ipc_pkg::*; #(
  parameter int unsigned DEPTH       = PF_DEPTH,
  parameter logic [7:0]  INT_TT_BASE = 8'h10
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire ipc_inst_s   inst_i,
  input  wire logic        memory_hold_i,
  input  wire logic        bus_grant_hold_i,
  input  wire logic        trap_req_i,
  input  wire logic [7:0]  trap_type_i,
  input  wire logic        trap_enable_bit_i,
  input  wire logic [3:0]  processor_interrupt_level_i,
  input  wire logic [31:0] trap_base_i,
  input  wire logic [3:0]  interrupt_level_in_i,
  input  wire logic        tristate_test_enable_i,
  output logic             fetch_o,
  output logic [31:0]      fetch_addr_o,
  output logic             iop_o,
  output logic             wr_en_o,
  output logic [4:0]       wr_rd_o,
  output logic             fwd_rs1_o,
  output logic             fwd_rs2_o,
  output logic             flush_o,
  output logic             interrupt_acknowledge_o,
  output logic             error_o,
  output logic [31:0]      saved_pc_o,
  output logic [31:0]      saved_npc_o,
  output logic [31:0]      trap_base_word_o,
  output logic             out_oe_n_o
);

  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic          rst_q;
  ipc_state_e    state_reg;
  ipc_state_e    state_next;
  ipc_inst_s     d_reg;
  ipc_inst_s     e_reg;
  ipc_inst_s     w_reg;
  ipc_inst_s     d_next;
  ipc_inst_s     e_next;
  ipc_inst_s     fetched;
  ipc_inst_s     buf_out;
  logic [31:0]   pc_reg;
  logic [31:0]   npc_reg;
  logic [31:0]   vec;
  logic [1:0]    icnt_reg;
  logic [1:0]    icnt_next;
  logic [1:0]    dcnt_reg;
  logic [1:0]    dcnt_next;
  ipc_cls_e      iop_cls_reg;
  logic          annul_reg;
  logic          annul_next;
  logic          int_blk_reg;
  logic [3:0]    lvl;
  logic [3:0]    lvl_taken_reg;
  logic [7:0]    tt;
  logic [CW-1:0] buf_free;
  logic          buf_valid;
  logic          buf_pop;
  logic          buf_push;
  logic          room;
  logic          hold;
  logic          adv;
  logic          haz_e;
  logic          haz_w;
  logic          stall;
  logic          d_take;
  logic          launch;
  logic          br_go;
  logic          br_annul;
  logic          err_now;
  logic          int_take;
  logic          trap_now;
  logic          kill;

  // The reset pin is sampled once; all control logic uses the copy.
  always_ff @(posedge clk_i) begin
    rst_q <= reset_i;
  end

  ipc_irl_sync #(
    .W (4)
  ) u_irl (
    .clk_i   (clk_i),
    .rst_i   (rst_q),
    .level_i (interrupt_level_in_i),
    .level_o (lvl)
  );

  ipc_prefetch_buf #(
    .DEPTH (DEPTH)
  ) u_pfb (
    .clk_i       (clk_i),
    .rst_i       (rst_q),
    .flush_i     (kill),
    .in_valid_i  (buf_push),
    .in_ready_o  (),
    .in_data_i   (fetched),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_out),
    .free_o      (buf_free)
  );

  // Holds and the error halt stop every stage at once.
  assign hold = memory_hold_i | bus_grant_hold_i;
  assign adv  = !hold && (state_reg != IPC_HALT);

  // Only memory loads and link writes interlock; ALU results bypass.
  assign haz_e = e_reg.vld && !e_reg.internal_op_insert && e_reg.rd != REG_G0
              && (e_reg.cls == IPC_CALL || e_reg.cls == IPC_REGISTER_JUMP)
              && (d_reg.rs1 == e_reg.rd || d_reg.rs2 == e_reg.rd);
  assign haz_w = w_reg.vld && !w_reg.internal_op_insert && w_reg.rd != REG_G0
              && (w_reg.cls == IPC_LD || w_reg.cls == IPC_LDD
                  || w_reg.cls == IPC_ATOM)
              && (d_reg.rs1 == w_reg.rd || d_reg.rs2 == w_reg.rd);
  assign stall  = d_reg.vld && !d_reg.internal_op_insert && (haz_e || haz_w);
  assign d_take = adv && !stall;
  assign launch = d_take && d_reg.vld && !d_reg.internal_op_insert
               && ipc_iops(d_reg.cls) != IOP_NONE;
  assign br_go  = d_take && d_reg.vld && !d_reg.internal_op_insert && d_reg.taken
               && (d_reg.cls == IPC_BR || d_reg.cls == IPC_CALL
                   || d_reg.cls == IPC_REGISTER_JUMP);
  assign br_annul = d_take && d_reg.vld && !d_reg.internal_op_insert
                 && d_reg.cls == IPC_BR && d_reg.annul;

  // Trap decisions happen in execute; a sync trap with traps off is fatal.
  assign err_now  = adv && state_reg == IPC_RUN && trap_req_i
                 && e_reg.vld && !trap_enable_bit_i;
  assign int_take = adv && state_reg == IPC_RUN && !trap_req_i
                 && trap_enable_bit_i && lvl != IRL_IDLE
                 && (lvl == IRL_NMI
                     || lvl > processor_interrupt_level_i)
                 && !int_blk_reg;
  assign trap_now = adv && state_reg == IPC_RUN
                 && ((trap_req_i && e_reg.vld && trap_enable_bit_i)
                     || int_take);
  assign kill = trap_now || err_now;
  assign tt   = int_take ? INT_TT_BASE + {4'h0, lvl} : trap_type_i;
  assign vec  = {trap_base_i[31:TBA_LSB], tt, TT_PAD};

  // Next fetch slot needs a free buffer entry after this edge.
  assign room = (buf_free + CW'(buf_pop)) > CW'(buf_push);

  // Decode source priority: inserted op, buffered, then fresh fetch.
  always_comb begin
    fetched     = inst_i;
    fetched.vld = 1'b1;
    fetched.internal_op_insert = 1'b0;
    fetched.pc  = pc_reg;
    d_next      = d_reg;
    e_next      = e_reg;
    icnt_next   = icnt_reg;
    buf_pop     = 1'b0;
    buf_push    = adv && fetch_o;
    annul_next  = annul_reg || br_annul;
    if (d_take) begin
      e_next = d_reg;
      if (launch || icnt_reg != IOP_NONE) begin
        d_next     = '0;
        d_next.vld = 1'b1;
        d_next.internal_op_insert = 1'b1;
        d_next.cls = launch ? d_reg.cls : iop_cls_reg;
        d_next.pc  = d_reg.pc;
        icnt_next  = launch ? ipc_iops(d_reg.cls) - IOP_ONE
                            : icnt_reg - IOP_ONE;
      end else if (buf_valid) begin
        d_next  = buf_out;
        buf_pop = 1'b1;
      end else begin
        d_next     = fetched;
        d_next.vld = fetch_o;
        buf_push   = 1'b0;
      end
      if (annul_next && d_next.vld && !d_next.internal_op_insert) begin
        d_next.vld = 1'b0;
        annul_next = 1'b0;
      end
    end else if (adv) begin
      e_next = '0;
    end
    if (kill) begin
      d_next     = '0;
      e_next     = '0;
      icnt_next  = IOP_NONE;
      buf_pop    = 1'b0;
      buf_push   = 1'b0;
      annul_next = 1'b0;
    end
  end

  // Data bus cycles of a multicycle instruction steal fetch slots.
  always_comb begin
    dcnt_next = dcnt_reg;
    if (kill) begin
      dcnt_next = IOP_NONE;
    end else if (launch) begin
      dcnt_next = ipc_dcyc(d_reg.cls);
    end else if (adv && dcnt_reg != IOP_NONE) begin
      dcnt_next = dcnt_reg - IOP_ONE;
    end
  end

  // One empty fetch slot after a trap puts the handler in execute on time.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IPC_RUN: begin
        if (err_now) begin
          state_next = IPC_HALT;
        end else if (trap_now) begin
          state_next = IPC_TRAP_GAP;
        end
      end
      IPC_TRAP_GAP: begin
        if (adv) begin
          state_next = IPC_RUN;
        end
      end
      IPC_HALT: state_next = IPC_HALT;
      default:  state_next = IPC_RUN;
    endcase
  end

  // Pipeline stage registers advance on each rising edge with adv high; a stall holds decode and sends a bubble to execute.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      state_reg   <= IPC_RUN;
      d_reg       <= '0;
      e_reg       <= '0;
      w_reg       <= '0;
      icnt_reg    <= IOP_NONE;
      dcnt_reg    <= IOP_NONE;
      iop_cls_reg <= IPC_ALU;
      annul_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      d_reg     <= d_next;
      e_reg     <= e_next;
      icnt_reg  <= icnt_next;
      dcnt_reg  <= dcnt_next;
      if (launch) begin
        iop_cls_reg <= d_reg.cls;
      end
      if (adv) begin
        annul_reg <= annul_next;
        w_reg     <= e_reg;
        w_reg.vld <= e_reg.vld && !kill;
      end
    end
  end

  // Fetch address; taken branches redirect after the delay slot.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      pc_reg  <= RESET_PC;
      npc_reg <= RESET_PC + INST_STEP;
    end else if (kill) begin
      pc_reg  <= vec;
      npc_reg <= vec + INST_STEP;
    end else if (adv && fetch_o) begin
      pc_reg  <= br_go ? d_reg.target : npc_reg;
      npc_reg <= (br_go ? d_reg.target : npc_reg) + INST_STEP;
    end else if (br_go) begin
      npc_reg <= d_reg.target;
    end
  end

  assign fetch_addr_o = pc_reg;
  assign iop_o        = d_reg.internal_op_insert;

  // The fetch strobe holds during a hold so memory sees a frozen request.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      fetch_o <= 1'b0;
    end else if (adv) begin
      fetch_o <= state_next == IPC_RUN && dcnt_next == IOP_NONE
              && room;
    end
  end

  // Write stage strobe and bypass selects for the op entering execute.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      wr_en_o   <= 1'b0;
      wr_rd_o   <= REG_G0;
      fwd_rs1_o <= 1'b0;
      fwd_rs2_o <= 1'b0;
    end else if (adv) begin
      wr_en_o   <= e_reg.vld && !e_reg.internal_op_insert && !kill
                && e_reg.rd != REG_G0;
      wr_rd_o   <= e_reg.rd;
      fwd_rs1_o <= d_take && e_reg.vld && e_reg.rd != REG_G0
                && d_reg.rs1 == e_reg.rd;
      fwd_rs2_o <= d_take && e_reg.vld && e_reg.rd != REG_G0
                && d_reg.rs2 == e_reg.rd;
    end else begin
      wr_en_o <= 1'b0;
    end
  end

  // Trap bookkeeping: error, saved pointers, trap word, flush and ack.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      error_o                 <= 1'b0;
      saved_pc_o              <= RESET_PC;
      saved_npc_o             <= RESET_PC;
      trap_base_word_o        <= RESET_PC;
      flush_o                 <= 1'b0;
      interrupt_acknowledge_o <= 1'b0;
    end else begin
      if (err_now) begin
        error_o <= 1'b1;
      end
      if (kill) begin
        saved_pc_o       <= e_reg.pc;
        saved_npc_o      <= d_reg.vld ? d_reg.pc : pc_reg;
        trap_base_word_o <= vec;
      end
      flush_o                 <= trap_now;
      interrupt_acknowledge_o <= int_take;
    end
  end

  // A taken level is ignored until the source changes it, so a
  // lagging synchronised copy is not taken twice.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      int_blk_reg   <= 1'b0;
      lvl_taken_reg <= IRL_IDLE;
    end else if (int_take) begin
      int_blk_reg   <= 1'b1;
      lvl_taken_reg <= lvl;
    end else if (lvl != lvl_taken_reg) begin
      int_blk_reg <= 1'b0;
    end
  end

  // Drivers released while test enable is low; reset keeps them off.
  always_ff @(posedge clk_i) begin
    if (rst_q) begin
      out_oe_n_o <= 1'b1;
    end else begin
      out_oe_n_o <= !tristate_test_enable_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_q);

  sequence s_handler;
    !fetch_o ##1 fetch_addr_o == trap_base_word_o;
  endsequence

  a_err_entry: assert property (
    err_now |=> error_o && state_reg == IPC_HALT
               && trap_base_word_o[11:4] == $past(trap_type_i))
    else $error("Error mode entry wrong.");
  a_err_sticky: assert property (
    error_o |=> error_o && !fetch_o && !wr_en_o)
    else $error("Error halt left without reset.");
  a_ack_taken: assert property (
    interrupt_acknowledge_o |-> $past(int_take) && flush_o)
    else $error("Acknowledge without a taken interrupt.");
  a_irl_idle: assert property (
    lvl == IRL_IDLE |-> !int_take)
    else $error("Interrupt taken at idle level.");
  a_nmi_take: assert property (
    adv && state_reg == IPC_RUN && trap_enable_bit_i && !trap_req_i
    && lvl == IRL_NMI && !int_blk_reg |-> int_take)
    else $error("Nonmaskable level not taken.");
  a_mask_low: assert property (
    lvl != IRL_NMI && lvl <= processor_interrupt_level_i |-> !int_take)
    else $error("Masked level taken.");
  a_reset_fetch: assert property (
    $fell(rst_q) |-> fetch_addr_o == RESET_PC && !fetch_o)
    else $error("Fetch does not restart at zero.");
  a_oe_test: assert property (
    !tristate_test_enable_i |=> out_oe_n_o)
    else $error("Drivers enabled in test isolation.");
  a_hold_freeze: assert property (
    hold |=> $stable(d_reg) && $stable(pc_reg) && !wr_en_o)
    else $error("Pipeline moved during hold.");
  a_iop_insert: assert property (
    launch && !kill |=> iop_o && d_reg.vld)
    else $error("No internal op after multicycle launch.");
  a_ld_gap: assert property (
    launch && !kill && d_reg.cls == IPC_LD |=> !fetch_o)
    else $error("Fetch not delayed by data cycle.");
  a_ld_stall: assert property (
    stall && adv && !kill |=> !e_reg.vld && $stable(d_reg))
    else $error("Load use not interlocked.");
  a_trap_handler: assert property (
    trap_now |=> s_handler)
    else $error("Handler fetch timing wrong.");
  a_trap_flush: assert property (
    trap_now |=> flush_o ##1 !flush_o)
    else $error("Flush not pulsed on trap.");

endmodule

/* File: verif/ipc_partner.sv */
module ipc_partner import ipc_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       set_i,
  input  wire logic [3:0] req_i,
  input  wire logic [1:0] hold_i,
  input  wire logic       ack_i,
  output logic      [3:0] level_o,
  output logic            mem_hold_o,
  output logic            bus_grant_hold_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // The level stays up until acknowledged, so a slow core still sees it.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      level_o <= IRL_IDLE;
    end else if (set_i) begin
      level_o <= req_i;
    end else if (ack_i) begin
      level_o <= IRL_IDLE;
    end
  end

  // Holds are registered, as bus logic would produce them.
  always_ff @(posedge clk_i) begin
    mem_hold_o       <= hold_i[0];
    bus_grant_hold_o <= hold_i[1];
  end
endmodule

/* File: verif/tb.sv */
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ipc_pkg::*;
  int          errors = 0;
  int          comparisons = 0;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  ipc_inst_s   inst_i = '0;
  logic        trap_req_i = 1'b0;
  logic [7:0]  trap_type_i = 8'h2a;
  logic        trap_en = 1'b1;
  logic [3:0]  processor_interrupt_level = 4'h0;
  logic [31:0] trap_base_i = 32'h1234_5000;
  logic        tristate_test_enable = 1'b1;
  logic        set_q = 1'b0;
  logic [3:0]  req_q = 4'h0;
  logic [1:0]  hold_q = 2'h0;
  logic [3:0]  level;
  logic        mhold;
  logic        bus_grant_hold;
  logic        fetch_o;
  logic [31:0] fetch_addr_o;
  logic        wr_en_o;
  logic [4:0]  wr_rd_o;
  logic        flush_o;
  logic        ack;
  logic        error_o;
  logic [31:0] tbw;
  logic        oe_n;
  logic        internal_op_insert;
  logic        fwd1;
  logic        fwd2;
  logic [31:0] spc;
  logic [31:0] snpc;

  ipc_core i_dut (.clk_i(clk_i), .reset_i(reset_i), .inst_i(inst_i),
    .memory_hold_i(mhold), .bus_grant_hold_i(bus_grant_hold), .trap_req_i(trap_req_i),
    .trap_type_i(trap_type_i), .trap_enable_bit_i(trap_en),
    .processor_interrupt_level_i(processor_interrupt_level), .trap_base_i(trap_base_i),
    .interrupt_level_in_i(level), .tristate_test_enable_i(tristate_test_enable), .fetch_o(fetch_o),
    .fetch_addr_o(fetch_addr_o), .iop_o(internal_op_insert), .wr_en_o(wr_en_o), .wr_rd_o(wr_rd_o),
    .fwd_rs1_o(fwd1), .fwd_rs2_o(fwd2), .flush_o(flush_o), .interrupt_acknowledge_o(ack),
    .error_o(error_o), .saved_pc_o(spc), .saved_npc_o(snpc), .trap_base_word_o(tbw),
    .out_oe_n_o(oe_n));

  ipc_partner i_partner (.clk_i(clk_i), .reset_i(reset_i), .set_i(set_q), .req_i(req_q),
    .hold_i(hold_q), .ack_i(ack), .level_o(level), .mem_hold_o(mhold),
    .bus_grant_hold_o(bus_grant_hold));

  // Free-running 250 MHz clock.
  always #2 clk_i = ~clk_i;

  function automatic ipc_inst_s mk(input ipc_cls_e c);
    mk = '0;
    mk.cls = c;
    mk.rd = 5'h03;
  endfunction

  task automatic results();
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Waits n edges, then lets their updates settle.
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    inst_i <= mk(IPC_ALU);
    step(1);
    `CHK("fetch lag", 1'b0, fetch_o)
    step(1);
    `CHK("fetch_o", 1'b1, fetch_o)
    `CHK("fetch_addr_o", RESET_PC, fetch_addr_o)
    `CHK("error_o", 1'b0, error_o)
    step(1);
    `CHK("next addr", RESET_PC + INST_STEP, fetch_addr_o)
    `CHK("early wr_en_o", 1'b0, wr_en_o)
    step(2);
    `CHK("wr_en_o", 1'b1, wr_en_o)
    `CHK("wr_rd_o", 5'h03, wr_rd_o)
  endtask

  task automatic t_toe();
    @(posedge clk_i);
    tristate_test_enable <= 1'b0;
    step(1);
    `CHK("oe off", 1'b1, oe_n)
    @(posedge clk_i);
    tristate_test_enable <= 1'b1;
    step(1);
    `CHK("oe on", 1'b0, oe_n)
  endtask

  // One multicycle instruction in an ALU stream; count the lost fetch slots.
  task automatic t_class();
    ipc_cls_e cl[6] = '{IPC_LD, IPC_LDD, IPC_ST, IPC_STD, IPC_ATOM, IPC_REGISTER_JUMP};
    int gap[6] = '{1, 2, 2, 3, 3, 0};
    int nio[6] = '{1, 2, 2, 3, 3, 1};
    int n;
    int m;
    foreach (cl[i]) begin
      step(4);
      do begin
        @(posedge clk_i);
        inst_i <= mk(cl[i]);
        #1;
      end while (fetch_o !== 1'b1);
      @(posedge clk_i);
      inst_i <= mk(IPC_ALU);
      n = 0;
      m = 0;
      repeat (14) begin
        step(1);
        if (fetch_o !== 1'b1) n++;
        if (internal_op_insert === 1'b1) m++;
      end
      `CHK("fetch gaps", gap[i], n)
      `CHK("iop_o count", nio[i], m)
    end
  endtask

  task automatic t_hold();
    logic [31:0] a;
    for (int h = 0; h < 2; h++) begin
      @(posedge clk_i);
      hold_q <= (h == 0) ? 2'h1 : 2'h2;
      step(3);
      a = fetch_addr_o;
      step(6);
      `CHK("frozen addr", a, fetch_addr_o)
      `CHK("frozen wr_en_o", 1'b0, wr_en_o)
      @(posedge clk_i);
      hold_q <= 2'h0;
      step(3);
      `CHK("resumed", 1'b1, fetch_addr_o !== a)
    end
  endtask

  // A reader right behind a producer: an ALU result is bypassed, a load interlocks.
  task automatic t_interlock();
    ipc_inst_s prod;
    ipc_inst_s dep;
    int        a;
    int        b;
    logic      f1;
    logic      f2;
    dep = mk(IPC_ALU);
    dep.rd = 5'h06;
    dep.rs1 = 5'h05;
    dep.rs2 = 5'h05;
    for (int k = 0; k < 2; k++) begin
      prod = mk(IPC_ALU);
      if (k == 1) prod = mk(IPC_LD);
      prod.rd = 5'h05;
      a = 0;
      b = 0;
      f1 = 1'b0;
      f2 = 1'b0;
      step(4);
      do begin
        @(posedge clk_i);
        inst_i <= prod;
        #1;
      end while (fetch_o !== 1'b1);
      @(posedge clk_i);
      inst_i <= dep;
      @(posedge clk_i);
      inst_i <= mk(IPC_ALU);
      for (int n = 1; n <= 12; n++) begin
        step(1);
        if (wr_en_o === 1'b1 && wr_rd_o === 5'h05) a = n;
        if (wr_en_o === 1'b1 && wr_rd_o === 5'h06) b = n;
        if (fwd1 === 1'b1) f1 = 1'b1;
        if (fwd2 === 1'b1) f2 = 1'b1;
      end
      `CHK("write distance", (k == 1) ? 3 : 1, b - a)
      `CHK("fwd_rs1_o", k == 0, f1)
      `CHK("fwd_rs2_o", k == 0, f2)
    end
  endtask

  task automatic t_trap(input logic en);
    logic [31:0] h;
    h = {trap_base_i[31:TBA_LSB], trap_type_i, TT_PAD};
    step(6);
    @(posedge clk_i);
    trap_en <= en;
    trap_req_i <= 1'b1;
    @(posedge clk_i);
    trap_req_i <= 1'b0;
    #1;
    `CHK("trap_base_word_o", h, tbw)
    `CHK("saved_npc_o", spc + INST_STEP, snpc)
    if (en) begin
      `CHK("flush_o", 1'b1, flush_o)
      `CHK("gap fetch", 1'b0, fetch_o)
      step(1);
      `CHK("handler fetch", 1'b1, fetch_o)
      `CHK("handler addr", h, fetch_addr_o)
    end else begin
      `CHK("error_o", 1'b1, error_o)
      step(20);
      `CHK("error held", 1'b1, error_o)
      `CHK("halted", 1'b0, fetch_o)
      t_reset();
      @(posedge clk_i);
      trap_en <= 1'b1;
    end
  endtask

  task automatic t_irq();
    logic [3:0] lv[5] = '{4'h5, 4'h2, 4'hf, 4'h5, 4'h0};
    logic [3:0] pl[5] = '{4'h3, 4'h3, 4'hf, 4'h3, 4'h0};
    logic       en[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    logic       ex[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    logic       seen;
    int         first;
    foreach (lv[i]) begin
      @(posedge clk_i);
      processor_interrupt_level <= pl[i];
      trap_en <= en[i];
      set_q <= 1'b1;
      req_q <= lv[i];
      @(posedge clk_i);
      set_q <= 1'b0;
      seen = 1'b0;
      first = 0;
      for (int n = 1; n <= 12; n++) begin
        step(1);
        if (ack === 1'b1 && !seen) begin
          seen = 1'b1;
          first = n;
          `CHK("irq flush", 1'b1, flush_o)
        end
      end
      `CHK("ack", ex[i], seen)
      if (seen) `CHK("ack delay", 1'b1, first >= 4)
      @(posedge clk_i);
      set_q <= 1'b1;
      req_q <= IRL_IDLE;
      @(posedge clk_i);
      set_q <= 1'b0;
      step(4);
    end
  endtask

  // Main sequence.
  initial begin
    t_reset();
    t_toe();
    t_class();
    t_interlock();
    t_hold();
    t_trap(1'b1);
    t_irq();
    t_trap(1'b0);
    results();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    results();
  end
endmodule
